//--- shared/psc_pkg.sv
// Constants for the page-size configuration and identification command block.
// Assumes an SPI mode 0/3 host sampling at the 100 MHz system clock.
package psc_pkg;
	// Opcodes of the configuration sequence, the identification read and the status read
	localparam logic [7:0] CFG_OP0 = 8'h3d;
	localparam logic [7:0] CFG_OP1 = 8'h2a;
	localparam logic [7:0] CFG_OP2 = 8'h80;
	localparam logic [7:0] CFG_OP3 = 8'ha6;
	localparam logic [7:0] ID_OP = 8'h9f;
	localparam logic [7:0] STAT_OP = 8'hd7;
	// Page sizes in bytes
	localparam int PAGE_BINARY = 512;
	localparam int PAGE_STANDARD = 528;
	// Status register bit positions
	localparam int STAT_RDY_BIT = 7;
	localparam int STAT_PSIZE_BIT = 0;
	// Fixed status bits 6..1 (compare, density code, protect) as held here
	localparam logic [5:0] STAT_MID = 6'h1a;
	// Identification bytes: arbitrary values, not any real maker's code
	localparam logic [7:0] ID_MFR_DEF = 8'h5a;
	localparam logic [7:0] ID_DEV1_DEF = 8'h11;
	localparam logic [7:0] ID_DEV2_DEF = 8'h01;
	localparam logic [7:0] ID_EXT_LEN = 8'h00;
	// Page program time and clock rate
	localparam int PAGE_PROGRAM_TIME_US = 4000;
	localparam int CLK_MHZ = 100;
	localparam int PROG_CYCLES = PAGE_PROGRAM_TIME_US * CLK_MHZ;
	// Frame states
	typedef enum logic [2:0] {
		PSC_IDLE = 3'b000,
		PSC_OPC = 3'b001,
		PSC_CFG = 3'b010,
		PSC_ID = 3'b011,
		PSC_STAT = 3'b100,
		PSC_IGN = 3'b101
	} psc_state_t;
endpackage

//--- verilog/psc_core.sv
// Serial command front end for page-size configuration, ID read and status read.
// Assumes cs_n, sck and si come from pins in another clock domain; the nonvolatile
// cell lives outside and is reached through nv_* ports.
`timescale 1ns/1ps
`default_nettype none
module psc_core #(
	parameter int PROG_CYCLES = psc_pkg::PROG_CYCLES,
	parameter logic [7:0] ID_MFR = psc_pkg::ID_MFR_DEF,
	parameter logic [7:0] ID_DEV1 = psc_pkg::ID_DEV1_DEF,
	parameter logic [7:0] ID_DEV2 = psc_pkg::ID_DEV2_DEF
) (
	// Clock and reset (reset stands for power-up)
	input wire logic sys_clk,
	input wire logic rst,
	// Serial pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic so,
	output logic so_oe_n,
	// Nonvolatile configuration cell
	input wire logic nv_binary,
	output logic nv_write,
	// Block state
	output logic binary_page,
	output logic [9:0] page_bytes,
	output logic busy,
	// Array-group busy from other blocks
	input wire logic array_busy
);
	if (PROG_CYCLES < 1)
	begin : g_bad_prog
		$error("PROG_CYCLES must be at least one");
	end

	// Pin synchronisers
	logic [1:0] cs_sync_ff, nxt_cs_sync;
	logic [1:0] sck_sync_ff, nxt_sck_sync;
	logic [1:0] si_sync_ff, nxt_si_sync;
	logic sck_prev_ff, nxt_sck_prev;
	// Frame state
	psc_pkg::psc_state_t state_ff, nxt_state;
	logic [7:0] shift_ff, nxt_shift;
	logic [2:0] bit_cnt_ff, nxt_bit_cnt;
	logic [1:0] byte_cnt_ff, nxt_byte_cnt;
	logic cfg_ok_ff, nxt_cfg_ok;
	logic [7:0] out_ff, nxt_out;
	logic so_ff, nxt_so;
	logic drive_ff, nxt_drive;
	// Programming and power-up copy
	logic [31:0] prog_cnt_ff, nxt_prog_cnt;
	logic prog_ff, nxt_prog;
	logic nvw_ff, nxt_nvw;
	logic binary_ff, nxt_binary;
	logic loaded_ff, nxt_loaded;
	// Decoded pin events
	logic cs_act, sck_rise, sck_fall, si_bit;
	logic [7:0] rx_byte;
	// Byte that an ID frame sends at a given index
	function automatic logic [7:0] id_byte(input logic [1:0] idx);
		case (idx)
			2'h0: id_byte = ID_MFR;
			2'h1: id_byte = ID_DEV1;
			2'h2: id_byte = ID_DEV2;
			default: id_byte = psc_pkg::ID_EXT_LEN;
		endcase
	endfunction
	// Live status byte
	function automatic logic [7:0] stat_byte(input logic rdy, input logic bin);
		stat_byte = {rdy, psc_pkg::STAT_MID, bin};
	endfunction
	// Synchroniser next values; only the second stage is read by logic
	always_comb
	begin
		nxt_cs_sync = {cs_sync_ff[0], cs_n};
		nxt_sck_sync = {sck_sync_ff[0], sck};
		nxt_si_sync = {si_sync_ff[0], si};
		nxt_sck_prev = sck_sync_ff[1];
	end
	assign cs_act = ~cs_sync_ff[1];
	assign sck_rise = sck_sync_ff[1] & ~sck_prev_ff;
	assign sck_fall = ~sck_sync_ff[1] & sck_prev_ff;
	assign si_bit = si_sync_ff[1];
	assign rx_byte = {shift_ff[6:0], si_bit};
	// Command decode and output shifter
	always_comb
	begin
		nxt_state = state_ff;
		nxt_shift = shift_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_byte_cnt = byte_cnt_ff;
		nxt_cfg_ok = cfg_ok_ff;
		nxt_out = out_ff;
		nxt_so = so_ff;
		nxt_drive = drive_ff;
		if (!cs_act)
		begin
			// Frame over: float SO at once, whatever the bit position
			nxt_state = psc_pkg::PSC_IDLE;
			nxt_drive = 1'b0;
			nxt_cfg_ok = 1'b0;
			nxt_bit_cnt = 3'h0;
			nxt_byte_cnt = 2'h0;
		end
		else
		begin
			case (state_ff)
				psc_pkg::PSC_IDLE:
				begin
					// New frame
					nxt_state = psc_pkg::PSC_OPC;
					nxt_cfg_ok = 1'b0;
					nxt_bit_cnt = 3'h0;
				end
				psc_pkg::PSC_OPC, psc_pkg::PSC_CFG:
				begin
					// Collect opcode bytes on rising edges
					if (sck_rise)
					begin
						nxt_shift = rx_byte;
						nxt_bit_cnt = bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h7)
						begin
							if (state_ff == psc_pkg::PSC_OPC)
							begin
								if (rx_byte == psc_pkg::CFG_OP0)
								begin
									nxt_state = psc_pkg::PSC_CFG;
									nxt_byte_cnt = 2'h1;
								end
								else if (rx_byte == psc_pkg::ID_OP)
								begin
									nxt_state = psc_pkg::PSC_ID;
									nxt_out = id_byte(2'h0);
									nxt_byte_cnt = 2'h1;
								end
								else if (rx_byte == psc_pkg::STAT_OP)
								begin
									nxt_state = psc_pkg::PSC_STAT;
									nxt_out = stat_byte(~busy, binary_ff);
								end
								else
									nxt_state = psc_pkg::PSC_IGN;
							end
							else
							begin
								// Check the remaining sequence bytes in order
								nxt_byte_cnt = byte_cnt_ff + 2'h1;
								case (byte_cnt_ff)
									2'h1: if (rx_byte != psc_pkg::CFG_OP1) nxt_state = psc_pkg::PSC_IGN;
									2'h2: if (rx_byte != psc_pkg::CFG_OP2) nxt_state = psc_pkg::PSC_IGN;
									default:
									begin
										nxt_state = psc_pkg::PSC_IGN;
										nxt_cfg_ok = (rx_byte == psc_pkg::CFG_OP3);
									end
								endcase
							end
						end
					end
				end
				psc_pkg::PSC_ID, psc_pkg::PSC_STAT:
				begin
					// Shift out MSB first on falling edges
					if (sck_fall)
					begin
						nxt_drive = 1'b1;
						nxt_so = out_ff[3'h7 - bit_cnt_ff];
						nxt_bit_cnt = bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h7)
						begin
							if (state_ff == psc_pkg::PSC_ID)
							begin
								nxt_out = id_byte(byte_cnt_ff);
								if (byte_cnt_ff != 2'h3)
									nxt_byte_cnt = byte_cnt_ff + 2'h1;
							end
							else
								nxt_out = stat_byte(~busy, binary_ff);
						end
					end
				end
				default:
				begin
					// Unknown or finished command: wait for chip select rise
					nxt_state = psc_pkg::PSC_IGN;
				end
			endcase
		end
	end
	// Programming timer, nonvolatile write and power-up copy
	always_comb
	begin
		nxt_prog = prog_ff;
		nxt_prog_cnt = prog_cnt_ff;
		nxt_nvw = 1'b0;
		nxt_binary = binary_ff;
		nxt_loaded = 1'b1;
		if (!loaded_ff)
			nxt_binary = nv_binary;
		if (!cs_act && cfg_ok_ff && !prog_ff && !array_busy)
		begin
			// Chip select rise after a complete sequence starts the cycle, unless array_busy is high or a cycle is already running
			nxt_prog = 1'b1;
			nxt_prog_cnt = 32'(PROG_CYCLES - 1);
		end
		else if (prog_ff)
		begin
			if (prog_cnt_ff == 32'h0)
			begin
				nxt_prog = 1'b0;
				// Cell only written at the end; early power loss keeps it unset
				nxt_nvw = 1'b1;
			end
			else
				nxt_prog_cnt = prog_cnt_ff - 32'h1;
		end
	end

	// Register update
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cs_sync_ff <= 2'h3;
			sck_sync_ff <= 2'h0;
			si_sync_ff <= 2'h0;
			sck_prev_ff <= 1'b0;
			state_ff <= psc_pkg::PSC_IDLE;
			shift_ff <= 8'h00;
			bit_cnt_ff <= 3'h0;
			byte_cnt_ff <= 2'h0;
			cfg_ok_ff <= 1'b0;
			out_ff <= 8'h00;
			so_ff <= 1'b0;
			drive_ff <= 1'b0;
			prog_cnt_ff <= 32'h0;
			prog_ff <= 1'b0;
			nvw_ff <= 1'b0;
			binary_ff <= 1'b0;
			loaded_ff <= 1'b0;
		end
		else
		begin
			cs_sync_ff <= nxt_cs_sync;
			sck_sync_ff <= nxt_sck_sync;
			si_sync_ff <= nxt_si_sync;
			sck_prev_ff <= nxt_sck_prev;
			state_ff <= nxt_state;
			shift_ff <= nxt_shift;
			bit_cnt_ff <= nxt_bit_cnt;
			byte_cnt_ff <= nxt_byte_cnt;
			cfg_ok_ff <= nxt_cfg_ok;
			out_ff <= nxt_out;
			so_ff <= nxt_so;
			drive_ff <= nxt_drive;
			prog_cnt_ff <= nxt_prog_cnt;
			prog_ff <= nxt_prog;
			nvw_ff <= nxt_nvw;
			binary_ff <= nxt_binary;
			loaded_ff <= nxt_loaded;
		end
	end

	// Outputs; the page size follows only the power-up copy
	assign so = so_ff;
	assign so_oe_n = ~drive_ff;
	assign nv_write = nvw_ff;
	assign binary_page = binary_ff;
	assign page_bytes = binary_ff ? 10'(psc_pkg::PAGE_BINARY) : 10'(psc_pkg::PAGE_STANDARD);
	assign busy = prog_ff | array_busy;
endmodule // psc_core
`default_nettype wire

//--- dv/psc_core_props.sv
// Checker for psc_core port behaviour.
// Assumes one sys_clk domain with async active-high rst.
`timescale 1ns/1ps
`default_nettype none
module psc_core_props #(
	parameter int PROG_CYCLES = 20
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Serial pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe_n,
	// Cell and state
	input wire logic nv_binary,
	input wire logic nv_write,
	input wire logic binary_page,
	input wire logic [9:0] page_bytes,
	input wire logic busy,
	input wire logic array_busy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Busy run length and cycles since reset
	logic [19:0] run_ff, nxt_run;
	logic [1:0] up_ff, nxt_up;
	always_comb
	begin
		nxt_run = busy ? run_ff + 20'h1 : 20'h0;
		nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
	end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			run_ff <= 20'h0;
			up_ff <= 2'h0;
		end
		else
		begin
			run_ff <= nxt_run;
			up_ff <= nxt_up;
		end
	end
	a_page_bytes: assert property (page_bytes == (binary_page ? 10'h200 : 10'h210))
		else $error("page size mismatch");
	a_size_held: assert property (up_ff == 2'h3 |-> $stable(binary_page))
		else $error("page size changed");
	a_array_busy: assert property (array_busy |-> ##[0:2] busy)
		else $error("array busy not shown");
	a_write_pulse: assert property (nv_write |=> !nv_write)
		else $error("write pulse too long");
	a_write_busy: assert property (nv_write |-> $past(busy))
		else $error("write without busy");
	a_prog_len: assert property (nv_write |-> run_ff + 20'h2 >= PROG_CYCLES && run_ff <= PROG_CYCLES + 2)
		else $error("program time wrong");
	a_busy_start: assert property ($rose(busy) && !array_busy |-> $past(cs_n, 2))
		else $error("busy inside frame");
	a_so_float: assert property ($rose(cs_n) |-> ##[0:5] so_oe_n)
		else $error("so still driven");
	a_so_idle: assert property (cs_n [*5] |-> so_oe_n)
		else $error("so driven while idle");
endmodule // psc_core_props
bind psc_core psc_core_props #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n),
	.sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n), .nv_binary(nv_binary), .nv_write(nv_write),
	.binary_page(binary_page), .page_bytes(page_bytes), .busy(busy), .array_busy(array_busy));
`default_nettype wire

//--- dv/psc_host.sv
// Host controller model: SPI mode 0 master, 80 ns sck.
// Assumes a 100 MHz sys_clk; tasks are called by the bench.
`timescale 1ns/1ps
`default_nettype none
module psc_host (
	// Clock
	input wire logic sys_clk,
	// Serial pins
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so
);
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
	end
	// Frame select; sck parks low, si flips so it never holds a value
	task automatic sel(input logic v);
		@(posedge sys_clk);
		// One frame at a time: status, ID and configuration frames, no group A, B or D command
		cs_n <= v;
		sck <= 1'b0;
		si <= ~si;
	endtask
	// Shift n bits MSB first, 4 clocks low and 4 high; so is taken at the edge ending the high phase
	task automatic xb(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			sck <= 1'b0;
			si <= tx[i];
			repeat (4) @(posedge sys_clk);
			sck <= 1'b1;
			repeat (4) @(posedge sys_clk);
			rx[i] = so;
		end
	endtask
endmodule // psc_host
`default_nettype wire

//--- dv/page_size_config_and_id_read_test.sv
// Self-checking bench for psc_core with the host model.
// Assumes PROG_CYCLES shortened to 400.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module page_size_config_and_id_read_test;
	logic sys_clk = 1'b0, rst = 1'b1, array_busy = 1'b0;
	logic cs_n, sck, si, so, so_oe_n, nv_write, binary_page, busy, nv_binary;
	logic [9:0] page_bytes;
	logic [7:0] rb [5];
	logic [7:0] t;
	int errors = 0, check_count = 0, cyc = 0;
	always #5 sys_clk = ~sys_clk;
	// Nonvolatile cell: blank until written, then only ever set
	always @(posedge sys_clk)
		nv_binary <= (nv_binary === 1'b1) || (nv_write === 1'b1);
	psc_core #(.PROG_CYCLES(400)) dut_u (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
		.so(so), .so_oe_n(so_oe_n), .nv_binary(nv_binary), .nv_write(nv_write), .binary_page(binary_page),
		.page_bytes(page_bytes), .busy(busy), .array_busy(array_busy));
	psc_host host_u (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so));
	task automatic end_sim;
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Timeout
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			errors++;
			end_sim();
		end
	end
	// One framed command, n bytes read back
	task automatic rd(input logic [7:0] op, input int n);
		host_u.sel(1'b0);
		host_u.xb(op, 8, t);
		for (int k = 0; k < n; k++)
			host_u.xb(8'h00, 8, rb[k]);
		host_u.sel(1'b1);
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic t_id;
		rd(psc_pkg::ID_OP, 5);
		`CHK(rb[0], psc_pkg::ID_MFR_DEF)
		`CHK(rb[1], psc_pkg::ID_DEV1_DEF)
		`CHK(rb[2], psc_pkg::ID_DEV2_DEF)
		`CHK(rb[3], psc_pkg::ID_EXT_LEN)
		`CHK(rb[4], 8'h00)
		`CHK(rb[0] == 8'h7f, 1'b0)
	endtask
	task automatic t_stat(input logic rdy, input logic bin);
		rd(psc_pkg::STAT_OP, 2);
		`CHK(rb[0], {rdy, psc_pkg::STAT_MID, bin})
		`CHK(rb[1], {rdy, psc_pkg::STAT_MID, bin})
	endtask
	task automatic t_cfg(input logic [7:0] b2, input logic [7:0] b3);
		host_u.sel(1'b0);
		host_u.xb(psc_pkg::CFG_OP0, 8, t);
		host_u.xb(psc_pkg::CFG_OP1, 8, t);
		host_u.xb(b2, 8, t);
		host_u.xb(b3, 8, t);
		host_u.sel(1'b1);
		repeat (8) @(posedge sys_clk);
	endtask
	task automatic pwr;
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
	// ID read cut in mid-byte floats so at once
	task automatic t_abort;
		host_u.sel(1'b0);
		host_u.xb(psc_pkg::ID_OP, 8, t);
		host_u.xb(8'h00, 3, t);
		`CHK(so_oe_n, 1'b0)
		`CHK(t[7:5], psc_pkg::ID_MFR_DEF[7:5])
		host_u.sel(1'b1);
		repeat (5) @(posedge sys_clk);
		`CHK(so_oe_n, 1'b1)
	endtask
	// Wrong byte order never starts programming
	task automatic t_cfg_bad;
		t_cfg(psc_pkg::CFG_OP3, psc_pkg::CFG_OP2);
		`CHK(busy, 1'b0)
	endtask
	// Power lost while programming leaves the cell blank
	task automatic t_lost;
		t_cfg(psc_pkg::CFG_OP2, psc_pkg::CFG_OP3);
		`CHK(busy, 1'b1)
		pwr();
		`CHK(busy, 1'b0)
		repeat (450) @(posedge sys_clk);
		`CHK(nv_binary, 1'b0)
		`CHK(page_bytes, 10'h210)
		t_stat(1'b1, 1'b0);
	endtask
	// Full programming cycle; the size changes only after a power cycle
	task automatic t_cfg_good;
		t_cfg(psc_pkg::CFG_OP2, psc_pkg::CFG_OP3);
		`CHK(busy, 1'b1)
		t_stat(1'b0, 1'b0);
		for (int k = 0; k < 600 && nv_binary !== 1'b1; k++)
			@(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
		`CHK(nv_binary, 1'b1)
		`CHK(busy, 1'b0)
		`CHK(page_bytes, 10'h210)
		pwr();
		`CHK(page_bytes, 10'h200)
		t_stat(1'b1, 1'b1);
	endtask
	// Queries still run while an array-group operation is self-timed
	task automatic t_array;
		array_busy <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK(busy, 1'b1)
		t_id();
		t_stat(1'b0, 1'b1);
		array_busy <= 1'b0;
		pwr();
		`CHK(binary_page, 1'b1)
	endtask
	initial
	begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		`CHK(page_bytes, 10'h210)
		t_id();
		t_stat(1'b1, 1'b0);
		t_abort();
		t_cfg_bad();
		t_lost();
		t_cfg_good();
		t_array();
		end_sim();
	end
endmodule // page_size_config_and_id_read_test
`default_nettype wire
